// ==== core/smb_buf2.sv ====
// Purpose: two-entry valid/ready buffer
// Assumes: one clock
// Notes: full and empty are exact
`timescale 1ns/1ps
`default_nettype none
module smb_buf2 #(
  parameter int W = 8
) (
  input wire logic clk, // clock
  input wire logic rst_n, // sync reset, low
  input wire logic in_valid, // word offered
  output logic in_ready, // room left
  input wire logic [W-1:0] in_data, // word in
  output logic out_valid, // word held
  input wire logic out_ready, // drain takes
  output logic [W-1:0] out_data // oldest word
);
  logic [W-1:0] mem_reg [2];
  logic wp_reg, rp_reg;
  logic [1:0] cnt_reg;
  logic push, pop;
  assign in_ready = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data = mem_reg[rp_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  // storage and pointers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wp_reg <= 1'b0;
      rp_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        mem_reg[wp_reg] <= in_data;
        wp_reg <= ~wp_reg;
      end
      if (pop)
        rp_reg <= ~rp_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// ==== core/smb_host.sv ====
// Purpose: host end issuing block write and block read
// Assumes: slave is far faster than the bus
// Notes: bus clock derived by divider, at most 100 kHz
`timescale 1ns/1ps
`default_nettype none
`include "smb_params.svh"
module smb_host
  import smb_pkg::*;
(
  input wire logic clk, // host clock
  input wire logic rst_n, // sync reset, low
  smb_link_if.host link, // two-wire link
  input wire logic req, // start a transfer, pulse
  input wire logic rd, // 1 block read, 0 block write
  input wire logic [7:0] index, // starting index
  input wire logic [7:0] count, // bytes to write / read
  input wire logic [7:0] wdata, // next write byte
  output logic wdata_take, // wdata consumed, pulse
  output logic rvalid, // read byte valid, pulse
  output logic [7:0] rdata, // read byte (count first)
  output logic done, // transfer over, pulse
  output logic nacked // slave failed to ack
);
  smb_host_st_t st_reg;
  logic [15:0] div_reg;
  logic [1:0] q_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg, left_reg;
  logic [2:0] step_reg;
  logic rd_reg, scl_reg, sda_reg, tx_reg;
  logic [1:0] sd_s_reg;
  logic tick;
  // divider: quarter-period ticks keep the clock at the limit
  assign tick = (div_reg == 16'((`SMB_HALF_CYC + 1) / 2));
  always_ff @(posedge clk)
  begin
    if (!rst_n || tick)
      div_reg <= 16'h0001;
    else
      div_reg <= div_reg + 16'h0001;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sd_s_reg <= 2'h3;
    else
      sd_s_reg <= {sd_s_reg[0], link.sda};
  end
  // sequencer: steps 0 addr wr, 1 index, 2 count, 3 data, 4 addr rd, 5 read
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_reg <= SMB_H_IDLE;
      q_reg <= 2'h0;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      left_reg <= 8'h00;
      step_reg <= 3'h0;
      rd_reg <= 1'b0;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      tx_reg <= 1'b1;
      wdata_take <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 8'h00;
      done <= 1'b0;
      nacked <= 1'b0;
    end
    else
    begin
      wdata_take <= 1'b0;
      rvalid <= 1'b0;
      done <= 1'b0;
      case (st_reg)
        SMB_H_IDLE:
          if (req)
          begin
            rd_reg <= rd;
            left_reg <= count;
            step_reg <= 3'h0;
            nacked <= 1'b0;
            q_reg <= 2'h0;
            st_reg <= SMB_H_START;
          end
        SMB_H_START, SMB_H_RSTART:
          if (tick)
          begin
            q_reg <= q_reg + 2'h1;
            // clock stays low while data is released, so a restart keeps a full low half
            if (q_reg == 2'h0)
              sda_reg <= 1'b1;
            if (q_reg == 2'h1)
              scl_reg <= 1'b1; // rise a whole bit after the last one
            if (q_reg == 2'h2)
              sda_reg <= 1'b0;
            if (q_reg == 2'h3)
            begin
              scl_reg <= 1'b0;
              sh_reg <= (st_reg == SMB_H_START) ? `SMB_ADDR_WR : `SMB_ADDR_RD;
              tx_reg <= 1'b1;
              bit_reg <= 4'h0;
              st_reg <= SMB_H_BYTE;
            end
          end
        SMB_H_BYTE, SMB_H_ACK:
          if (tick)
          begin
            q_reg <= q_reg + 2'h1;
            if (q_reg == 2'h0)
            begin
              if (st_reg == SMB_H_ACK)
                sda_reg <= tx_reg | (left_reg == 8'h00); // ack all but last
              else
                sda_reg <= tx_reg ? sh_reg[7] : 1'b1;
            end
            if (q_reg == 2'h1) scl_reg <= 1'b1;
            if (q_reg == 2'h2)
            begin
              if (st_reg == SMB_H_BYTE)
                sh_reg <= {sh_reg[6:0], sd_s_reg[1]};
              else if (tx_reg && sd_s_reg[1])
                nacked <= 1'b1;
            end
            if (q_reg == 2'h3)
            begin
              scl_reg <= 1'b0;
              if (st_reg == SMB_H_BYTE)
              begin
                bit_reg <= bit_reg + 4'h1;
                if (bit_reg == 4'h7)
                  st_reg <= SMB_H_ACK;
              end
              else
              begin
                bit_reg <= 4'h0;
                tx_reg <= 1'b1;
                if (!tx_reg)
                begin
                  rvalid <= 1'b1;
                  rdata <= sh_reg;
                end
                if (nacked)
                  st_reg <= SMB_H_STOP;
                else
                begin
                  st_reg <= SMB_H_BYTE;
                  case (step_reg)
                    3'h0: begin sh_reg <= index; step_reg <= 3'h1; end
                    3'h1:
                      if (rd_reg)
                      begin
                        st_reg <= SMB_H_RSTART; // restart, not stop
                        step_reg <= 3'h4;
                      end
                      else
                      begin
                        sh_reg <= count;
                        step_reg <= 3'h2;
                      end
                    3'h2, 3'h3:
                      if (left_reg == 8'h00)
                        st_reg <= SMB_H_STOP;
                      else
                      begin
                        sh_reg <= wdata;
                        wdata_take <= 1'b1;
                        left_reg <= left_reg - 8'h01;
                        step_reg <= 3'h3;
                      end
                    3'h4, 3'h5:
                      if (step_reg == 3'h5 && left_reg == 8'h00)
                        st_reg <= SMB_H_STOP; // after nack
                      else
                      begin
                        tx_reg <= 1'b0;
                        if (step_reg == 3'h5)
                          left_reg <= left_reg - 8'h01;
                        step_reg <= 3'h5;
                      end
                    default: st_reg <= SMB_H_STOP;
                  endcase
                end
              end
            end
          end
        SMB_H_STOP:
          if (tick)
          begin
            q_reg <= q_reg + 2'h1;
            if (q_reg == 2'h0) sda_reg <= 1'b0;
            if (q_reg == 2'h1) scl_reg <= 1'b1;
            if (q_reg == 2'h2) sda_reg <= 1'b1;
            if (q_reg == 2'h3) st_reg <= SMB_H_DONE;
          end
        SMB_H_DONE:
        begin
          done <= 1'b1;
          st_reg <= SMB_H_IDLE;
        end
        default: st_reg <= SMB_H_IDLE;
      endcase
    end
  end
  assign link.scl_oe = ~scl_reg;
  assign link.sda_host_oe = ~sda_reg;
endmodule
`default_nettype wire

// ==== core/smb_link_if.sv ====
// Purpose: two-wire link between host and slave
// Assumes: open-drain wires, low wins
// Notes: enables high while an end drives low
`timescale 1ns/1ps
`default_nettype none
interface smb_link_if;
  logic scl_oe; // host pulls clock low
  logic sda_host_oe; // host pulls data low
  logic sda_dev_oe; // slave pulls data low
  logic scl; // resolved clock level
  logic sda; // resolved data level
  // data is the wired-and of both ends, clock follows the host alone; pull-up otherwise
  assign scl = ~scl_oe;
  assign sda = ~(sda_host_oe | sda_dev_oe);
  modport host (output scl_oe, output sda_host_oe, input scl, input sda);
  modport dev (output sda_dev_oe, input scl, input sda);
endinterface
`default_nettype wire

// ==== core/smb_params.svh ====
// Purpose: timing counts and codes for the indexed block slave link
// Assumes: included by name from core files
// Notes: definitions only
`ifndef SMB_PARAMS_SVH
`define SMB_PARAMS_SVH
`define SMB_ADDR_WR 8'hdc
`define SMB_ADDR_RD 8'hdd
`define SMB_NUM_REGS 8
`define SMB_IDX_W 3
`define SMB_CNT_IDX 3'h6
`define SMB_CNT_RST 8'h07
`define SMB_ID_IDX 3'h5
`define SMB_VR_IDX 3'h4
`define SMB_SCL_MAX_KHZ 100
`define SMB_CLK_MHZ 25
// half bus period in clk cycles, rounded up so the rate never exceeds the limit
`define SMB_HALF_CYC ((`SMB_CLK_MHZ * 1000 + 2 * `SMB_SCL_MAX_KHZ - 1) / (2 * `SMB_SCL_MAX_KHZ))
`endif

// ==== core/smb_pkg.sv ====
// Purpose: shared types for the block slave and its host
// Assumes: nothing
// Notes: states of the host command sequencer
package smb_pkg;
  typedef enum logic [3:0] {
    SMB_H_IDLE = 4'h0,
    SMB_H_START = 4'h1,
    SMB_H_BYTE = 4'h2,
    SMB_H_ACK = 4'h3,
    SMB_H_STOP = 4'h4,
    SMB_H_RSTART = 4'h5,
    SMB_H_DONE = 4'h6
  } smb_host_st_t;
endpackage

// ==== core/smb_slave.sv ====
// Functional notes
// - acknowledge write address after start
// - acknowledge read address after restart, then transmit
// - acknowledge starting index byte
// - acknowledge byte count before write data
// - acknowledge every written data byte
// - host ends write with stop
// - host restarts, not stops, before read
// - send count then bytes from index
// - host acks all read bytes but last
// - host nack and stop; release data
// - respond only while reference clock runs
// - bus clock at most 100 kHz
// - read length from writable count register
//
// Purpose: indexed block slave, clocked by the reference input clock
// Assumes: link lines sampled through two flops; bus far slower than clock
// Notes: written bytes cross to the user domain through a toggle and buffer
`timescale 1ns/1ps
`default_nettype none
`include "smb_params.svh"
module smb_slave
  import smb_pkg::*;
#(
  parameter logic [7:0] DEV_ID = 8'h5a, // arbitrary value
  parameter logic [7:0] VEN_REV = 8'h11 // arbitrary value
) (
  input wire logic diff_ref_clock_in, // reference clock, runs the slave
  input wire logic ref_rst_n, // sync reset in reference domain
  smb_link_if.dev link, // two-wire link
  input wire logic clk, // user clock
  input wire logic rst_n, // user reset
  output logic wr_valid, // written byte available
  input wire logic wr_ready, // user takes it
  output logic [10:0] wr_data, // {index, byte}
  output logic busy // transfer in progress
);
  // -----------------------------------------------------------
  // link sampling
  // -----------------------------------------------------------
  logic [1:0] scl_s_reg, sda_s_reg;
  logic scl_d_reg, sda_d_reg;
  logic scl_rise, scl_fall, start_c, stop_c;
  // two flops per pin plus a delay flop; logic reads the second flop and the delay flop
  always_ff @(posedge diff_ref_clock_in)
  begin
    if (!ref_rst_n)
    begin
      scl_s_reg <= 2'h3;
      sda_s_reg <= 2'h3;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_s_reg <= {scl_s_reg[0], link.scl};
      sda_s_reg <= {sda_s_reg[0], link.sda};
      scl_d_reg <= scl_s_reg[1];
      sda_d_reg <= sda_s_reg[1];
    end
  end
  assign scl_rise = scl_s_reg[1] & ~scl_d_reg;
  assign scl_fall = ~scl_s_reg[1] & scl_d_reg;
  assign start_c = scl_s_reg[1] & scl_d_reg & sda_d_reg & ~sda_s_reg[1];
  assign stop_c = scl_s_reg[1] & scl_d_reg & ~sda_d_reg & sda_s_reg[1];

  // -----------------------------------------------------------
  // byte engine
  // -----------------------------------------------------------
  // phase: 0 addr, 1 index, 2 count, 3 write data, 4 read count, 5 read data, 7 ignore
  logic [2:0] ph_reg;
  logic [7:0] sh_reg;
  logic [3:0] bit_reg;
  logic ack_reg, tx_reg, oe_reg, act_reg;
  logic [`SMB_IDX_W-1:0] idx_reg;
  logic [7:0] regs_reg [`SMB_NUM_REGS];
  logic [7:0] rd_byte;
  logic [7:0] rx_byte;
  logic wr_tgl_reg;
  logic [10:0] wr_hold_reg;
  // identity bytes are fixed, everything else comes from storage
  always_comb
  begin
    if (idx_reg == `SMB_ID_IDX)
      rd_byte = DEV_ID;
    else if (idx_reg == `SMB_VR_IDX)
      rd_byte = VEN_REV;
    else
      rd_byte = regs_reg[idx_reg];
  end
  assign rx_byte = {sh_reg[6:0], sda_d_reg};
  // bit counting, ack slots and data-line drive
  always_ff @(posedge diff_ref_clock_in)
  begin
    if (!ref_rst_n)
    begin
      ph_reg <= 3'h7;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      ack_reg <= 1'b0;
      tx_reg <= 1'b0;
      oe_reg <= 1'b0;
      act_reg <= 1'b0;
      idx_reg <= '0;
      wr_tgl_reg <= 1'b0;
      wr_hold_reg <= 11'h000;
      for (int i = 0; i < `SMB_NUM_REGS; i++)
        regs_reg[i] <= (i == `SMB_CNT_IDX) ? `SMB_CNT_RST : 8'h00;
    end
    else if (stop_c)
    begin
      ph_reg <= 3'h7;
      oe_reg <= 1'b0; // release after stop
      act_reg <= 1'b0;
    end
    else if (start_c)
    begin
      ph_reg <= 3'h0; // repeated start keeps the index
      bit_reg <= 4'h0;
      ack_reg <= 1'b0;
      tx_reg <= 1'b0;
      oe_reg <= 1'b0;
      act_reg <= 1'b1;
    end
    else if (ph_reg != 3'h7)
    begin
      if (scl_rise && !ack_reg && !tx_reg)
      begin
        sh_reg <= rx_byte;
        bit_reg <= bit_reg + 4'h1;
        if (bit_reg == 4'h7)
        begin
          ack_reg <= 1'b1;
          case (ph_reg)
            3'h0:
            begin
              if (rx_byte == `SMB_ADDR_WR)
                ph_reg <= 3'h1;
              else if (rx_byte == `SMB_ADDR_RD)
                ph_reg <= 3'h4;
              else
              begin
                ph_reg <= 3'h7;
                ack_reg <= 1'b0;
              end
            end
            3'h1:
            begin
              idx_reg <= rx_byte[`SMB_IDX_W-1:0];
              ph_reg <= 3'h2;
            end
            3'h2: ph_reg <= 3'h3; // count taken, acked
            3'h3:
            begin
              regs_reg[idx_reg] <= rx_byte; // count register writable too
              wr_hold_reg <= {idx_reg, rx_byte};
              wr_tgl_reg <= ~wr_tgl_reg;
              idx_reg <= idx_reg + {{(`SMB_IDX_W-1){1'b0}}, 1'b1};
            end
            default: ph_reg <= ph_reg;
          endcase
        end
      end
      else if (scl_rise && tx_reg)
      begin
        bit_reg <= bit_reg + 4'h1;
        if (bit_reg == 4'h8)
        begin
          bit_reg <= 4'h0;
          // after an ack the slave keeps the line, so the next fall loads the next byte
          if (sda_d_reg)
          begin
            tx_reg <= 1'b0;
            ph_reg <= 3'h7; // nack ends the read
          end
          else if (ph_reg == 3'h4)
            ph_reg <= 3'h5;
          else
            idx_reg <= idx_reg + {{(`SMB_IDX_W-1){1'b0}}, 1'b1};
        end
      end
      else if (scl_fall)
      begin
        if (ack_reg && !oe_reg)
          oe_reg <= 1'b1; // ack
        else if (ack_reg)
        begin
          ack_reg <= 1'b0;
          oe_reg <= 1'b0;
          bit_reg <= 4'h0;
          if (ph_reg == 3'h4)
          begin
            tx_reg <= 1'b1;
            sh_reg <= regs_reg[`SMB_CNT_IDX]; // count first
            oe_reg <= ~regs_reg[`SMB_CNT_IDX][7];
          end
        end
        else if (tx_reg)
        begin
          if (bit_reg == 4'h0 && ph_reg == 3'h5)
          begin
            sh_reg <= rd_byte;
            oe_reg <= ~rd_byte[7];
          end
          else if (bit_reg < 4'h8)
          begin
            sh_reg <= {sh_reg[6:0], 1'b1};
            oe_reg <= ~sh_reg[6];
          end
          else
            oe_reg <= 1'b0; // host ack slot
        end
      end
    end
  end
  assign link.sda_dev_oe = oe_reg;

  // -----------------------------------------------------------
  // crossing to user clock
  // -----------------------------------------------------------
  logic [2:0] tg_s_reg;
  logic [1:0] bz_s_reg;
  logic bf_ready, bf_valid;
  logic [10:0] bf_data;
  // toggle crossing; data is stable many cycles since bus is slow
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tg_s_reg <= 3'h0;
      bz_s_reg <= 2'h0;
      busy <= 1'b0;
      wr_valid <= 1'b0;
      wr_data <= 11'h000;
    end
    else
    begin
      tg_s_reg <= {tg_s_reg[1:0], wr_tgl_reg};
      bz_s_reg <= {bz_s_reg[0], act_reg};
      busy <= bz_s_reg[1];
      if (!wr_valid || wr_ready)
      begin
        wr_valid <= bf_valid;
        wr_data <= bf_data;
      end
    end
  end
  // a full buffer drops the byte; at bus speed the user never lags two bytes
  smb_buf2 #(.W(11)) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(tg_s_reg[2] ^ tg_s_reg[1]),
    .in_ready(bf_ready),
    .in_data(wr_hold_reg),
    .out_valid(bf_valid),
    .out_ready(!wr_valid || wr_ready),
    .out_data(bf_data)
  );
endmodule
`default_nettype wire

// ==== dv/smb_link_properties.sv ====
// Purpose: watch the two-wire link between host and slave
// Assumes: clk far faster than the bus clock
// Notes: frames decoded straight from the wires
`timescale 1ns/1ps
`default_nettype none
module smb_link_properties (
  input wire logic clk, // host clock
  input wire logic rst_n, // host reset, low
  input wire logic scl_oe, // host pulls clock
  input wire logic sda_host_oe, // host pulls data
  input wire logic sda_dev_oe, // slave pulls data
  input wire logic scl, // clock level
  input wire logic sda // data level
);
  logic scl_q, sda_q, ack_hi, rd_mode, wr_ok, rise, start, ack_slot;
  logic [3:0] bit_cnt;
  logic [2:0] byte_no;
  logic [7:0] sh;
  logic [9:0] per_cnt;
  // ----------------------------------------
  // frame decode
  // ----------------------------------------
  assign rise = scl & ~scl_q;
  assign start = scl & scl_q & sda_q & ~sda;
  assign ack_slot = rise & (bit_cnt == 4'h8);
  // line history; period count saturates so the first edge is never judged
  always_ff @(posedge clk)
  begin
    scl_q <= scl | ~rst_n;
    sda_q <= sda | ~rst_n;
    ack_hi <= rst_n & (ack_slot | (ack_hi & scl));
    per_cnt <= !rst_n ? 10'h3ff : rise ? 10'h1 : per_cnt + {9'h0, per_cnt != 10'h3ff};
  end
  // bit and byte position within the frame
  always_ff @(posedge clk)
  begin
    if (!rst_n || start)
    begin
      bit_cnt <= 4'h0;
      byte_no <= 3'h0;
    end
    else if (ack_slot)
    begin
      bit_cnt <= 4'h0;
      byte_no <= byte_no + {2'h0, byte_no != 3'h7};
    end
    else if (rise)
    begin
      bit_cnt <= bit_cnt + 4'h1;
      sh <= {sh[6:0], sda};
    end
  end
  // direction of the frame; a host nack hands the line back
  always_ff @(posedge clk)
  begin
    if (!rst_n || start)
    begin
      rd_mode <= 1'b0;
      wr_ok <= 1'b0;
    end
    else if (ack_slot && byte_no == 3'h0)
    begin
      wr_ok <= sh == 8'hdc;
      rd_mode <= sh == 8'hdd;
    end
    else if (ack_slot && sda)
      rd_mode <= 1'b0;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_wr_addr_ack: assert property (ack_slot && byte_no == 3'h0 && sh == 8'hdc |-> sda_dev_oe && !sda)
    else $error("write address not acknowledged");
  a_rd_addr_ack: assert property (ack_slot && byte_no == 3'h0 && sh == 8'hdd |-> sda_dev_oe)
    else $error("read address not acknowledged");
  a_index_ack: assert property (ack_slot && byte_no == 3'h1 && wr_ok |-> sda_dev_oe)
    else $error("index byte not acknowledged");
  a_count_ack: assert property (ack_slot && byte_no == 3'h2 && wr_ok |-> sda_dev_oe)
    else $error("count byte not acknowledged");
  a_data_ack: assert property (ack_slot && byte_no >= 3'h3 && wr_ok |-> sda_dev_oe)
    else $error("data byte not acknowledged");
  a_dev_steady_hi: assert property (scl && scl_q |-> $stable(sda_dev_oe))
    else $error("slave moved data while clock high");
  a_host_quiet: assert property (rd_mode && scl && scl_q && !ack_hi |-> !sda_host_oe)
    else $error("host drove a slave data bit");
  a_dev_quiet: assert property (!rd_mode && scl && scl_q && !ack_hi |-> !sda_dev_oe)
    else $error("slave drove outside its slots");
  a_scl_rate: assert property (rise |-> per_cnt >= 10'd250 && !scl_oe)
    else $error("bus clock too fast");
  c_write_data: cover property (ack_slot && byte_no == 3'h3 && wr_ok);
  c_read_nack: cover property (ack_slot && rd_mode && sda);
  c_restart: cover property (start && byte_no == 3'h2);
endmodule
`default_nettype wire

// ==== dv/smbus_indexed_block_slave_test.sv ====
// Purpose: host and slave joined across the link
// Assumes: host makes the bus clock from clk
// Notes: expectations come from a register mirror
`timescale 1ns/1ps
`default_nettype none
module smbus_indexed_block_slave_test;
  localparam logic [7:0] DEV_ID = 8'h3c; // arbitrary value
  localparam logic [7:0] VEN_REV = 8'h21; // arbitrary value
  logic clk = 1'b0, ref_clk = 1'b0, rst_n = 1'b0, ref_rst_n = 1'b0;
  logic req = 1'b0, rd = 1'b0, wr_ready = 1'b0;
  logic [7:0] index = 8'h0, count = 8'h0, wdata = 8'h0;
  logic wdata_take, rvalid, done, nacked, wr_valid, busy;
  logic [7:0] rdata;
  logic [10:0] wr_data;
  logic [7:0] regs [8] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h07, 8'h0};
  logic [7:0] wbuf [8];
  logic [10:0] expq [$];
  integer seed = 32'h45a2;
  int n_mismatch = 0, check_count = 0;
  smb_link_if smb_link_if_i ();
  smb_host smb_host_i (.clk(clk), .rst_n(rst_n), .link(smb_link_if_i.host), .req(req), .rd(rd), .index(index),
    .count(count), .wdata(wdata), .wdata_take(wdata_take), .rvalid(rvalid), .rdata(rdata), .done(done),
    .nacked(nacked));
  smb_slave #(.DEV_ID(DEV_ID), .VEN_REV(VEN_REV)) smb_slave_i (.diff_ref_clock_in(ref_clk),
    .ref_rst_n(ref_rst_n), .link(smb_link_if_i.dev), .clk(clk), .rst_n(rst_n), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .busy(busy));
  smb_link_properties smb_link_properties_i (.clk(clk), .rst_n(rst_n), .scl_oe(smb_link_if_i.scl_oe),
    .sda_host_oe(smb_link_if_i.sda_host_oe), .sda_dev_oe(smb_link_if_i.sda_dev_oe), .scl(smb_link_if_i.scl),
    .sda(smb_link_if_i.sda));
  // ----------------------------------------
  // clocks, reset, user stalls
  // ----------------------------------------
  always #20 clk = ~clk;
  // reference clock free of any phase tie to clk
  initial
  begin
    #7;
    forever #24 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) ref_rst_n <= rst_n;
  // one stall in four stays well inside the two-entry buffer
  always @(posedge clk) wr_ready <= ($random(seed) & 3) != 0;
  // ----------------------------------------
  // checking
  // ----------------------------------------
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // identity bytes read back fixed, the rest from storage
  function automatic logic [7:0] exp_byte(input logic [2:0] i);
    return (i == 3'h5) ? DEV_ID : (i == 3'h4) ? VEN_REV : regs[i];
  endfunction
  // written bytes leave the slave in order with their index
  always @(posedge clk)
    if (rst_n && wr_valid === 1'b1 && wr_ready === 1'b1)
    begin
      check(wr_data, (expq.size() > 0) ? expq[0] : 11'h7ff);
      if (expq.size() > 0)
        void'(expq.pop_front());
    end
  // one block transfer; entered just after a clk edge
  task automatic xfer(input logic r, input logic [2:0] idx, input logic [7:0] cnt);
    int n = 0;
    int k = 0;
    int w = 0;
    logic [2:0] p = idx;
    logic nxt = 1'b0;
    logic seen_busy = 1'b0;
    logic [7:0] xc = regs[6];
    if (!r)
      for (int i = 0; i < cnt; i++)
      begin
        expq.push_back({idx + i[2:0], wbuf[i]});
        regs[idx + i[2:0]] = wbuf[i];
      end
    rd <= r;
    index <= {5'h0, idx};
    count <= cnt;
    wdata <= wbuf[0];
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    while (done !== 1'b1 && w < 30000)
    begin
      @(posedge clk);
      if (nxt)
        wdata <= wbuf[k[2:0]];
      #1;
      nxt = wdata_take === 1'b1;
      k = k + int'(nxt);
      seen_busy = seen_busy | (busy === 1'b1);
      if (rvalid === 1'b1)
      begin
        check({3'h0, rdata}, {3'h0, (n == 0) ? xc : exp_byte(p)});
        p = (n == 0) ? p : p + 3'h1;
        n++;
      end
      w++;
    end
    check({10'h0, done}, 11'h1);
    check({10'h0, nacked}, 11'h0);
    check({10'h0, seen_busy}, 11'h1);
    check(11'(n), r ? 11'(cnt) + 11'h1 : 11'h0);
    repeat (20) @(posedge clk);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    foreach (wbuf[i])
      wbuf[i] = 8'($random(seed));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    xfer(1'b1, 3'h4, 8'h2);
    $display("test reset_read done");
    wbuf[0] = 8'h03;
    xfer(1'b0, 3'h6, 8'h2);
    $display("test count_write done");
    wbuf[0] = 8'($random(seed));
    xfer(1'b0, 3'h7, 8'h2);
    xfer(1'b1, 3'h6, 8'h3);
    $display("test wrap done");
    repeat (2)
    begin
      foreach (wbuf[i])
        wbuf[i] = 8'($random(seed));
      xfer(1'($random(seed)), 3'($random(seed) & 3), 8'h1);
    end
    $display("test random done");
    repeat (200) @(posedge clk);
    check(11'(expq.size()), 11'h0);
    test_done();
  end
  // hang guard, about a fifth beyond the expected run
  initial
  begin
    #(95000 * 40);
    n_mismatch++;
    test_done();
  end
endmodule
`default_nettype wire
